// ### design/pt2_pkg.sv
// constants for the port two latch, input mode and match block
package pt2_pkg;
   localparam int PT2_PINS = 7;
   localparam logic [7:0] PT2_PAGE_CFG = 8'h20;
   localparam logic [7:0] PT2_ADDR_LATCH = 8'hA0;
   localparam logic [7:0] PT2_ADDR_INMODE = 8'hF3;
   localparam logic [7:0] PT2_ADDR_MATCH = 8'hFB;
   localparam logic [7:0] PT2_ADDR_MASK = 8'hFC;
   localparam logic [7:0] PT2_ADDR_OUTMODE = 8'hA6;
   localparam logic [7:0] PT2_RST_LATCH = 8'h7F;
   localparam logic [7:0] PT2_RST_INMODE = 8'hFF;
   localparam logic [7:0] PT2_RST_MATCH = 8'hFF;
   localparam logic [7:0] PT2_RST_MASK = 8'h00;
   localparam logic [7:0] PT2_RST_OUTMODE = 8'h00;
   localparam int PT2_FIXED_BIT = 7;
endpackage

// ### design/pt2_port.sv
// port two pin latch, input mode, match and mismatch compare
// Functional notes
// - each match bit is the level its pin is compared against, 0 low, 1 high.
// - the seven match bits reset to 1.
// - writing the pin latch sets the output level of digital pins.
// - reading the pin latch returns the sampled pin levels, not the latch.
// - latch 0 drives low, latch 1 drives high or releases when open-drain.
// - an input mode bit of 0 selects analog use and 1 digital use.
// - the seven input mode bits reset to 1.
// - the pin latch sits at 0xA0 on every page, with bit and byte access.
// - the match register sits at 0xFB on page 0x20 only.
// - the input mode register sits at 0xF3 on page 0x20 only.
// - only pins with mask bit 1 can cause a mismatch.
// - output mode 0 is open-drain and 1 is push-pull.
`timescale 1ns/100ps
`default_nettype none
module pt2_port
   import pt2_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset,
   input wire logic [7:0] sfr_page,
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_bit_wr,
   input wire logic [2:0] sfr_bit_sel,
   input wire logic sfr_bit_val,
   output logic [7:0] sfr_rdata,
   output logic sfr_sel,
   input wire logic [PT2_PINS-1:0] pad_in,
   output logic [PT2_PINS-1:0] pad_out,
   output logic [PT2_PINS-1:0] pad_oe,
   output logic [PT2_PINS-1:0] pad_pullup_en,
   output logic [PT2_PINS-1:0] pad_rx_en,
   output logic [PT2_PINS-1:0] pad_analog,
   output logic port_mismatch
);
   typedef struct packed {
      logic [PT2_PINS-1:0] latch;
      logic [PT2_PINS-1:0] inmode;
      logic [PT2_PINS-1:0] match;
      logic [PT2_PINS-1:0] mask;
      logic [PT2_PINS-1:0] outmode;
      logic [PT2_PINS-1:0] sync1;
      logic [PT2_PINS-1:0] sync2;
      logic [7:0] rdata;
      logic mismatch;
   } pt2_state_t;

   pt2_state_t state_reg;
   pt2_state_t state_next;

   logic hit_latch;
   logic hit_inmode;
   logic hit_match;
   logic hit_mask;
   logic hit_outmode;
   logic [7:0] bit_image;
   logic [PT2_PINS-1:0] rx_level;

   assign hit_latch = (sfr_addr == PT2_ADDR_LATCH);
   assign hit_inmode = (sfr_page == PT2_PAGE_CFG)
      && (sfr_addr == PT2_ADDR_INMODE);
   assign hit_match = (sfr_page == PT2_PAGE_CFG)
      && (sfr_addr == PT2_ADDR_MATCH);
   assign hit_mask = (sfr_page == PT2_PAGE_CFG)
      && (sfr_addr == PT2_ADDR_MASK);
   assign hit_outmode = (sfr_addr == PT2_ADDR_OUTMODE);
   assign sfr_sel = hit_latch | hit_inmode | hit_match | hit_mask
      | hit_outmode;
   // receiver gated off in analog mode, reads low
   assign rx_level = state_reg.sync2 & state_reg.inmode;

   always_comb begin
      state_next = state_reg;
      state_next.sync1 = pad_in;
      state_next.sync2 = state_reg.sync1;
      // bit access is read-modify-write on the pin latch only
      bit_image = {1'b0, state_reg.latch};
      bit_image[sfr_bit_sel] = sfr_bit_val;
      if (sfr_wr && hit_latch) begin
         state_next.latch = sfr_wdata[PT2_PINS-1:0];
      end else if (sfr_bit_wr && hit_latch) begin
         state_next.latch = bit_image[PT2_PINS-1:0];
      end
      if (sfr_wr && hit_inmode) begin
         state_next.inmode = sfr_wdata[PT2_PINS-1:0];
      end
      if (sfr_wr && hit_match) begin
         state_next.match = sfr_wdata[PT2_PINS-1:0];
      end
      if (sfr_wr && hit_mask) begin
         state_next.mask = sfr_wdata[PT2_PINS-1:0];
      end
      if (sfr_wr && hit_outmode) begin
         state_next.outmode = sfr_wdata[PT2_PINS-1:0];
      end
      state_next.rdata = 8'h00;
      if (sfr_rd) begin
         if (hit_latch) begin
            state_next.rdata = {PT2_RST_LATCH[PT2_FIXED_BIT],
               rx_level};
         end else if (hit_inmode) begin
            state_next.rdata = {PT2_RST_INMODE[PT2_FIXED_BIT],
               state_reg.inmode};
         end else if (hit_match) begin
            state_next.rdata = {PT2_RST_MATCH[PT2_FIXED_BIT],
               state_reg.match};
         end else if (hit_mask) begin
            state_next.rdata = {PT2_RST_MASK[PT2_FIXED_BIT],
               state_reg.mask};
         end else if (hit_outmode) begin
            state_next.rdata = {PT2_RST_OUTMODE[PT2_FIXED_BIT],
               state_reg.outmode};
         end else begin
            state_next.rdata = 8'h00;
         end
      end
      // analog pins never compare since the compare is gated by their input mode bit
      state_next.mismatch = |(state_reg.mask & state_reg.inmode
         & (rx_level ^ state_reg.match));
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         state_reg.latch <= PT2_RST_LATCH[PT2_PINS-1:0];
         state_reg.inmode <= PT2_RST_INMODE[PT2_PINS-1:0];
         state_reg.match <= PT2_RST_MATCH[PT2_PINS-1:0];
         state_reg.mask <= PT2_RST_MASK[PT2_PINS-1:0];
         state_reg.outmode <= PT2_RST_OUTMODE[PT2_PINS-1:0];
         state_reg.sync1 <= '0;
         state_reg.sync2 <= '0;
         state_reg.rdata <= 8'h00;
         state_reg.mismatch <= 1'b0;
      end else begin
         state_reg <= state_next;
      end
   end

   // open-drain drives only the low level; push-pull drives both
   assign pad_out = state_reg.latch;
   assign pad_oe = state_reg.inmode
      & (~state_reg.latch | state_reg.outmode);
   assign pad_pullup_en = state_reg.inmode;
   assign pad_rx_en = state_reg.inmode;
   assign pad_analog = ~state_reg.inmode;
   assign sfr_rdata = state_reg.rdata;
   assign port_mismatch = state_reg.mismatch;

   // open-drain high pins released, push-pull digital pins always driven
   property p_oe_rule;
      @(posedge core_clk) disable iff (reset)
      ((state_reg.inmode & state_reg.latch & ~state_reg.outmode & pad_oe)
         | (state_reg.inmode & state_reg.outmode & ~pad_oe)) == '0;
   endproperty
   a_oe_rule: assert property (p_oe_rule) else $error("oe wrong");

   property p_latch_write;
      @(posedge core_clk) disable iff (reset)
      (sfr_wr && hit_latch) |=> pad_out == $past(sfr_wdata[6:0]);
   endproperty
   a_latch_write: assert property (p_latch_write)
      else $error("latch write lost");

   property p_match_write;
      @(posedge core_clk) disable iff (reset)
      (sfr_wr && hit_match) |=> state_reg.match == $past(sfr_wdata[6:0]);
   endproperty
   a_match_write: assert property (p_match_write)
      else $error("match write lost");

   property p_page_gate;
      @(posedge core_clk) disable iff (reset)
      (sfr_page != PT2_PAGE_CFG) |=> $stable(state_reg.inmode);
   endproperty
   a_page_gate: assert property (p_page_gate)
      else $error("inmode changed off page");

   property p_read_pins;
      @(posedge core_clk) disable iff (reset)
      (sfr_rd && hit_latch) |=> sfr_rdata[6:0] == $past(rx_level)
         && sfr_rdata[7] == 1'b0;
   endproperty
   a_read_pins: assert property (p_read_pins)
      else $error("latch read not pin level");

   property p_analog_off;
      @(posedge core_clk) disable iff (reset)
      ((pad_pullup_en | pad_rx_en | pad_oe) & pad_analog) == '0;
   endproperty
   a_analog_off: assert property (p_analog_off)
      else $error("analog pin not isolated");

   property p_mask_gate;
      @(posedge core_clk) disable iff (reset)
      (state_reg.mask == '0) |=> !port_mismatch;
   endproperty
   a_mask_gate: assert property (p_mask_gate)
      else $error("masked mismatch");

   property p_match_read;
      @(posedge core_clk) disable iff (reset)
      (sfr_rd && hit_match) |=> sfr_rdata == {1'b1, $past(state_reg.match)};
   endproperty
   a_match_read: assert property (p_match_read)
      else $error("match read wrong");

   // sync flops restart at 0, so wait two clean edges before checking
   sequence s_settled;
      !reset ##1 !reset;
   endsequence

   // pin level reaches the read path after exactly two flops
   property p_sync_depth;
      @(posedge core_clk) disable iff (reset)
      s_settled |=> rx_level == ($past(pad_in, 2) & state_reg.inmode);
   endproperty
   a_sync_depth: assert property (p_sync_depth)
      else $error("pin path depth wrong");

   // high pin against a low reference must flag
   property p_high_pin;
      @(posedge core_clk) disable iff (reset)
      (|(state_reg.mask & rx_level & ~state_reg.match)) |=> port_mismatch;
   endproperty
   a_high_pin: assert property (p_high_pin)
      else $error("high pin mismatch missed");

   // low digital pin against a high reference must flag
   property p_low_pin;
      @(posedge core_clk) disable iff (reset)
      (|(state_reg.mask & state_reg.inmode & ~rx_level & state_reg.match))
         |=> port_mismatch;
   endproperty
   a_low_pin: assert property (p_low_pin)
      else $error("low pin mismatch missed");
endmodule
`default_nettype wire

// ### dv/pt2_pads.sv
// pad model for the seven port pins
`timescale 1ns/100ps
`default_nettype none
module pt2_pads
   import pt2_pkg::*;
(
   input wire logic [PT2_PINS-1:0] pad_out,
   input wire logic [PT2_PINS-1:0] pad_oe,
   input wire logic [PT2_PINS-1:0] pad_pullup_en,
   input wire logic [PT2_PINS-1:0] ext_low,
   output logic [PT2_PINS-1:0] pad_in
);
   // a pin with no pullup and no driver floats, so show the inverse
   always_comb begin
      for (int i = 0; i < PT2_PINS; i++) begin
         if (pad_oe[i])
            pad_in[i] = pad_out[i];
         else if (ext_low[i])
            pad_in[i] = 1'b0;
         else
            pad_in[i] = pad_pullup_en[i] | ~pad_out[i];
      end
   end
endmodule
`default_nettype wire

// ### dv/testbench.sv
// self-checking bench for the port two block
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) chk(8'(a), 8'(b))
module testbench;
   import pt2_pkg::*;
   logic core_clk = 0, reset = 1, sfr_wr = 0, sfr_rd = 0, sfr_bit_wr = 0;
   logic sfr_bit_val = 0, sfr_sel, port_mismatch;
   logic [7:0] sfr_page = 0, sfr_addr = 0, sfr_wdata = 0, sfr_rdata;
   logic [2:0] sfr_bit_sel = 0;
   logic [6:0] pad_in, pad_out, pad_oe, pad_pullup_en, pad_rx_en, pad_analog;
   logic [6:0] ext_low = 0;
   int fails = 0, samples_checked = 0;
   always #5 core_clk = ~core_clk;
   pt2_port dut (.core_clk(core_clk), .reset(reset), .sfr_page(sfr_page),
      .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
      .sfr_wdata(sfr_wdata), .sfr_bit_wr(sfr_bit_wr),
      .sfr_bit_sel(sfr_bit_sel), .sfr_bit_val(sfr_bit_val),
      .sfr_rdata(sfr_rdata), .sfr_sel(sfr_sel), .pad_in(pad_in),
      .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup_en(pad_pullup_en),
      .pad_rx_en(pad_rx_en), .pad_analog(pad_analog),
      .port_mismatch(port_mismatch));
   pt2_pads pads (.pad_out(pad_out), .pad_oe(pad_oe),
      .pad_pullup_en(pad_pullup_en), .ext_low(ext_low), .pad_in(pad_in));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] pg, input logic [7:0] a,
                     input logic [7:0] d);
      @(negedge core_clk);
      {sfr_page, sfr_addr, sfr_wdata, sfr_wr} = {pg, a, d, 1'b1};
      @(negedge core_clk);
      sfr_wr = 0;
      repeat (5) @(negedge core_clk);
   endtask
   task automatic rd(input logic [7:0] pg, input logic [7:0] a,
                     input logic [7:0] exp);
      @(negedge core_clk);
      {sfr_page, sfr_addr, sfr_rd} = {pg, a, 1'b1};
      @(negedge core_clk);
      sfr_rd = 0;
      `CHK(sfr_rdata, exp);
   endtask
   task automatic report_and_stop;
      $display("checks=%0d fails=%0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic t_reset;
      rd(8'h20, PT2_ADDR_INMODE, 8'hFF);
      rd(8'h20, PT2_ADDR_MATCH, 8'hFF);
      rd(8'h00, PT2_ADDR_LATCH, 8'h7F);
      `CHK(sfr_sel, 1'b1);
      rd(8'h20, 8'h55, 8'h00);
      `CHK(sfr_sel, 1'b0);
      `CHK(pad_out, 8'h7F);
      `CHK(pad_oe, 8'h00);
      `CHK(pad_analog, 8'h00);
   endtask
   task automatic t_latch;
      wr(8'h00, PT2_ADDR_LATCH, 8'h85);
      `CHK(pad_out, 8'h05);
      `CHK(pad_oe, 8'h7A);
      ext_low = 7'h01;
      // let the new pin level through both sync flops first
      repeat (2) @(negedge core_clk);
      rd(8'h20, PT2_ADDR_LATCH, 8'h04);
      ext_low = 0;
      @(negedge core_clk);
      {sfr_addr, sfr_bit_sel, sfr_bit_val, sfr_bit_wr} =
         {PT2_ADDR_LATCH, 3'd1, 1'b1, 1'b1};
      @(negedge core_clk);
      sfr_bit_wr = 0;
      repeat (5) @(negedge core_clk);
      rd(8'h00, PT2_ADDR_LATCH, 8'h07);
      wr(8'h00, PT2_ADDR_OUTMODE, 8'h7F);
      `CHK(pad_oe, 8'h7F);
   endtask
   task automatic t_mode;
      wr(8'h20, PT2_ADDR_INMODE, 8'h7E);
      `CHK(pad_analog, 8'h01);
      `CHK(pad_oe, 8'h7E);
      `CHK(pad_pullup_en | pad_rx_en, 8'h7E);
      wr(8'h00, PT2_ADDR_INMODE, 8'h00);
      `CHK(sfr_sel, 1'b0);
      rd(8'h20, PT2_ADDR_INMODE, 8'hFE);
      wr(8'h20, PT2_ADDR_INMODE, 8'hFF);
   endtask
   task automatic t_match;
      wr(8'h00, PT2_ADDR_OUTMODE, 8'h00);
      wr(8'h00, PT2_ADDR_LATCH, 8'h7F);
      wr(8'h20, PT2_ADDR_MASK, 8'h01);
      `CHK(port_mismatch, 1'b0);
      wr(8'h20, PT2_ADDR_MATCH, 8'h00);
      `CHK(port_mismatch, 1'b1);
      rd(8'h20, PT2_ADDR_MATCH, 8'h80);
      wr(8'h00, PT2_ADDR_MATCH, 8'h7F);
      `CHK(port_mismatch, 1'b1);
      `CHK(sfr_sel, 1'b0);
      wr(8'h20, PT2_ADDR_MASK, 8'h00);
      `CHK(port_mismatch, 1'b0);
      wr(8'h20, PT2_ADDR_MATCH, 8'h7F);
      wr(8'h20, PT2_ADDR_MASK, 8'h01);
      ext_low = 7'h01;
      // two sync flops plus the mismatch flop
      repeat (4) @(negedge core_clk);
      `CHK(port_mismatch, 1'b1);
      wr(8'h20, PT2_ADDR_INMODE, 8'h7E);
      `CHK(port_mismatch, 1'b0);
      ext_low = 0;
      wr(8'h20, PT2_ADDR_INMODE, 8'hFF);
      reset = 1;
      repeat (2) @(negedge core_clk);
      reset = 0;
      `CHK(pad_oe, 8'h00);
      rd(8'h20, PT2_ADDR_MATCH, 8'hFF);
      rd(8'h20, PT2_ADDR_INMODE, 8'hFF);
   endtask
   initial begin
      repeat (16) @(negedge core_clk);
      reset = 0;
      t_reset();
      t_latch();
      t_mode();
      t_match();
      report_and_stop();
   end
   // whole run is under two hundred cycles
   initial begin
      #100us;
      fails++;
      report_and_stop();
   end
endmodule
`default_nettype wire
